// ---- mifeb_bank.v ----
/*
 Interrupt request and enable bank: three special-function registers, grouped source
 merging, enable gating, fixed priority and service acknowledge.
 Assumes the CPU drives sfr_sel/sfr_wr/sfr_addr synchronously, holds a request open
 until it pulses irq_ack, and that source inputs are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`include "mifeb_regs.vh"
// Overview of operation
// - Only timer compare and tick sources exist
// - Accepted request signals CPU to suspend program
// - Hardware sets flags, software writes enables
// - Two primary registers plus grouped-source register
// - Grouped register: A flag5, P flag4, A en1, P en0
// - Every source has enable and flag, global enable only
// - Global enable bit0 of primary A, resets 0
// - Tick flag bit5, enable bit2, reset 0
// - Unimplemented bits read zero, ignore writes
// - Interrupt needs own enable and global enable
// - Grouped flag set by sub-flags, auto-cleared on service
// - Service entry clears global enable, flags still record
module mifeb_bank (
  input wire clk, // System clock, 40 MHz
  input wire rst_n, // Async reset, active low
  input wire sfr_sel, // Register access strobe
  input wire sfr_wr, // 1 write, 0 read
  input wire [1:0] sfr_addr, // Register select
  input wire [7:0] sfr_wdata, // Write data
  output reg [7:0] sfr_rdata, // Read data, registered
  input wire tick_overflow, // Time-base overflow pulse
  input wire cmp_p_match, // Timer comparator P match pulse
  input wire cmp_a_match, // Timer comparator A match pulse
  output wire irq_req, // Interrupt request to CPU
  output wire [1:0] irq_vector, // Vector of request
  input wire irq_ack // CPU entering service, one pulse
);
  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  function wr_hit;
    input sel;
    input wr;
    input [1:0] addr;
    input [1:0] ofs;
    begin
      wr_hit = sel & wr & (addr == ofs);
    end
  endfunction

  wire wr_a = wr_hit(sfr_sel, sfr_wr, sfr_addr, `MIFEB_OFS_PRIMARY_A);
  wire wr_b = wr_hit(sfr_sel, sfr_wr, sfr_addr, `MIFEB_OFS_PRIMARY_B);
  wire wr_g = wr_hit(sfr_sel, sfr_wr, sfr_addr, `MIFEB_OFS_GROUPED);

  // ---------------------------------------------------------------
  // Enable bits
  // ---------------------------------------------------------------
  reg global_irq_enable_reg;
  reg tick_irq_enable_reg;
  reg grouped_irq_enable_reg;
  reg cmp_p_match_enable_reg;
  reg cmp_a_match_enable_reg;
  wire ack_taken;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_reg <= `MIFEB_RST_BIT;
      tick_irq_enable_reg <= `MIFEB_RST_BIT;
      grouped_irq_enable_reg <= `MIFEB_RST_BIT;
      cmp_p_match_enable_reg <= `MIFEB_RST_BIT;
      cmp_a_match_enable_reg <= `MIFEB_RST_BIT;
    end else begin
      if (ack_taken) begin
        global_irq_enable_reg <= 1'b0;
      end else if (wr_a) begin
        global_irq_enable_reg <= sfr_wdata[`MIFEB_BIT_GLOBAL_EN];
      end
      if (wr_a) begin
        tick_irq_enable_reg <= sfr_wdata[`MIFEB_BIT_TICK_EN];
      end
      if (wr_b) begin
        grouped_irq_enable_reg <= sfr_wdata[`MIFEB_BIT_GROUPED_EN];
      end
      if (wr_g) begin
        cmp_p_match_enable_reg <= sfr_wdata[`MIFEB_BIT_CMP_P_EN];
        cmp_a_match_enable_reg <= sfr_wdata[`MIFEB_BIT_CMP_A_EN];
      end
    end
  end

  // ---------------------------------------------------------------
  // Request flags
  // ---------------------------------------------------------------
  wire tick_irq_flag;
  wire grouped_irq_flag;
  wire cmp_p_match_flag;
  wire cmp_a_match_flag;
  wire svc_tick;
  wire svc_grouped;

  // Sub-source flags are cleared only by software
  wire [1:0] sub_set = {cmp_a_match, cmp_p_match};
  wire [1:0] sub_wval = {sfr_wdata[`MIFEB_BIT_CMP_A_FLAG], sfr_wdata[`MIFEB_BIT_CMP_P_FLAG]};
  wire [1:0] sub_flag;
  wire [1:0] sub_en = {cmp_a_match_enable_reg, cmp_p_match_enable_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sub
      mifeb_sticky_flag u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set_pulse(sub_set[gi]),
        .clr_pulse(1'b0),
        .wr_en(wr_g),
        .wr_val(sub_wval[gi]),
        .flag_reg(sub_flag[gi])
      );
    end
  endgenerate

  assign cmp_p_match_flag = sub_flag[0];
  assign cmp_a_match_flag = sub_flag[1];

  // Grouped flag rises on a new enabled sub-source request
  reg [1:0] sub_flag_d_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_flag_d_reg <= 2'h0;
    end else begin
      sub_flag_d_reg <= sub_flag & sub_en;
    end
  end
  wire grouped_set = |((sub_flag & sub_en) & ~sub_flag_d_reg);

  mifeb_sticky_flag u_grouped (
    .clk(clk),
    .rst_n(rst_n),
    .set_pulse(grouped_set),
    .clr_pulse(svc_grouped),
    .wr_en(wr_b),
    .wr_val(sfr_wdata[`MIFEB_BIT_GROUPED_FLAG]),
    .flag_reg(grouped_irq_flag)
  );

  mifeb_sticky_flag u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .set_pulse(tick_overflow),
    .clr_pulse(svc_tick),
    .wr_en(wr_a),
    .wr_val(sfr_wdata[`MIFEB_BIT_TICK_FLAG]),
    .flag_reg(tick_irq_flag)
  );

  // ---------------------------------------------------------------
  // Gating, priority and service
  // ---------------------------------------------------------------
  wire tick_pend = tick_irq_flag & tick_irq_enable_reg;
  wire grouped_pend = grouped_irq_flag & grouped_irq_enable_reg;
  assign irq_req = global_irq_enable_reg & (tick_pend | grouped_pend);
  assign irq_vector = !irq_req ? `MIFEB_VEC_NONE :
                      tick_pend ? `MIFEB_VEC_TICK : `MIFEB_VEC_GROUPED;
  assign ack_taken = irq_ack & irq_req;
  assign svc_tick = ack_taken & tick_pend;
  assign svc_grouped = ack_taken & ~tick_pend & grouped_pend;

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  reg [7:0] rd_next;
  always @* begin
    rd_next = `MIFEB_RST_BYTE;
    case (sfr_addr)
      `MIFEB_OFS_PRIMARY_A: begin
        rd_next[`MIFEB_BIT_GLOBAL_EN] = global_irq_enable_reg;
        rd_next[`MIFEB_BIT_TICK_EN] = tick_irq_enable_reg;
        rd_next[`MIFEB_BIT_TICK_FLAG] = tick_irq_flag;
      end
      `MIFEB_OFS_PRIMARY_B: begin
        rd_next[`MIFEB_BIT_GROUPED_EN] = grouped_irq_enable_reg;
        rd_next[`MIFEB_BIT_GROUPED_FLAG] = grouped_irq_flag;
      end
      `MIFEB_OFS_GROUPED: begin
        rd_next[`MIFEB_BIT_CMP_P_EN] = cmp_p_match_enable_reg;
        rd_next[`MIFEB_BIT_CMP_A_EN] = cmp_a_match_enable_reg;
        rd_next[`MIFEB_BIT_CMP_P_FLAG] = cmp_p_match_flag;
        rd_next[`MIFEB_BIT_CMP_A_FLAG] = cmp_a_match_flag;
      end
      default: begin
        rd_next = `MIFEB_RST_BYTE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= `MIFEB_RST_BYTE;
    end else if (sfr_sel & ~sfr_wr) begin
      sfr_rdata <= rd_next;
    end
  end
endmodule // mifeb_bank

// ---- mifeb_regs.vh ----
/*
 Register offsets, bit positions and reset values for the interrupt flag and enable bank.
 Assumes the CPU special-function register decoder supplies the offsets below.
*/
`ifndef MIFEB_REGS_VH
`define MIFEB_REGS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define MIFEB_OFS_PRIMARY_A 2'h0
`define MIFEB_OFS_PRIMARY_B 2'h1
`define MIFEB_OFS_GROUPED 2'h2
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define MIFEB_BIT_GLOBAL_EN 0
`define MIFEB_BIT_TICK_EN 2
`define MIFEB_BIT_TICK_FLAG 5
`define MIFEB_BIT_GROUPED_EN 0
`define MIFEB_BIT_GROUPED_FLAG 4
`define MIFEB_BIT_CMP_P_EN 0
`define MIFEB_BIT_CMP_A_EN 1
`define MIFEB_BIT_CMP_P_FLAG 4
`define MIFEB_BIT_CMP_A_FLAG 5
// ---------------------------------------------------------------
// Reset values and vector codes
// ---------------------------------------------------------------
`define MIFEB_RST_BIT 1'b0
`define MIFEB_RST_BYTE 8'h00
`define MIFEB_VEC_NONE 2'h0
`define MIFEB_VEC_TICK 2'h1
`define MIFEB_VEC_GROUPED 2'h2
`endif

// ---- mifeb_sticky_flag.v ----
/*
 One sticky request flag: hardware set wins over software or service clear.
 Assumes set, clear and write strobes are synchronous to clk.
*/
`timescale 1ns/1ps
`include "mifeb_regs.vh"
module mifeb_sticky_flag (
  input wire clk, // System clock
  input wire rst_n, // Async reset, active low
  input wire set_pulse, // Hardware event
  input wire clr_pulse, // Automatic clear on service
  input wire wr_en, // Software write of this bit
  input wire wr_val, // Value written
  output reg flag_reg // Flag state
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= `MIFEB_RST_BIT;
    end else if (set_pulse) begin
      flag_reg <= 1'b1;
    end else if (clr_pulse) begin
      flag_reg <= 1'b0;
    end else if (wr_en) begin
      flag_reg <= wr_val;
    end
  end
endmodule // mifeb_sticky_flag

// ---- mifeb_bank_properties.sv ----
/* Port checker for the interrupt bank.
 Assumes a bind onto mifeb_bank from the bench top. */
`timescale 1ns/1ps
`include "mifeb_regs.vh"
module mifeb_bank_properties (
  input wire clk, // Clock
  input wire rst_n, // Reset
  input wire sfr_sel, // Strobe
  input wire sfr_wr, // Write
  input wire [1:0] sfr_addr, // Address
  input wire [7:0] sfr_wdata, // Write data
  input wire [7:0] sfr_rdata, // Read data
  input wire tick_overflow, // Tick
  input wire cmp_p_match, // Match P
  input wire cmp_a_match, // Match A
  input wire irq_req, // Request
  input wire [1:0] irq_vector, // Vector
  input wire irq_ack // Ack
);
  wire rd = sfr_sel & ~sfr_wr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_vector: assert property (irq_req |-> irq_vector inside {`MIFEB_VEC_TICK, `MIFEB_VEC_GROUPED})
    else $error("request without vector");
  a_ack_drops_req: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request stays after ack");
  a_unmapped_zero: assert property (rd && sfr_addr == 2'h3 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_a_zero: assert property (rd && sfr_addr == 2'h0 |=> (sfr_rdata & 8'hda) == 8'h00)
    else $error("reserved bit set in primary a");
  a_rsvd_b_zero: assert property (rd && sfr_addr == 2'h1 |=> (sfr_rdata & 8'hee) == 8'h00)
    else $error("reserved bit set in primary b");
  a_rsvd_grp_zero: assert property (rd && sfr_addr == 2'h2 |=> (sfr_rdata & 8'hcc) == 8'h00)
    else $error("reserved bit set in grouped");
  a_tick_flag_set: assert property (tick_overflow ##1 (rd && sfr_addr == 2'h0) |=> sfr_rdata[5])
    else $error("tick flag not set");
  a_cmp_a_flag: assert property (cmp_a_match ##1 (rd && sfr_addr == 2'h2) |=> sfr_rdata[5])
    else $error("match a flag not set");
  a_cmp_p_flag: assert property (cmp_p_match ##1 (rd && sfr_addr == 2'h2) |=> sfr_rdata[4])
    else $error("match p flag not set");
endmodule // mifeb_bank_properties

// ---- mifeb_bank_tb.sv ----
/* Self-checking bench for the interrupt bank.
 Assumes the design files and register header are compiled first. */
`timescale 1ns/1ps
`include "mifeb_regs.vh"
module mifeb_bank_tb;
  localparam [31:0] MASKS = 32'h00331125;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg sfr_sel = 1'b0;
  reg sfr_wr = 1'b0;
  reg [1:0] sfr_addr = 2'h0;
  reg [7:0] sfr_wdata = 8'h00;
  reg [3:0] ev = 4'h0;
  reg rd_seen = 1'b0;
  reg [31:0] seed = 32'h0001352c;
  reg [7:0] exp_q [$];
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  wire [7:0] sfr_rdata;
  wire irq_req;
  wire [1:0] irq_vector;
  wire tick_overflow = ev[0];
  wire cmp_p_match = ev[1];
  wire cmp_a_match = ev[2];
  wire irq_ack = ev[3];
  always #12.5 clk = ~clk;
  mifeb_bank i_mifeb_bank (.clk, .rst_n, .sfr_sel, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .tick_overflow, .cmp_p_match, .cmp_a_match, .irq_req, .irq_vector, .irq_ack);
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task check(input [7:0] seen, input [7:0] want);
    begin
      compares = compares + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task finish_test;
    begin
      if (bad_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Read notes its expected byte in the queue
  task acc(input w, input [1:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1;
      sfr_sel = 1'b1;
      sfr_wr = w;
      sfr_addr = a;
      sfr_wdata = d;
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      #1;
      sfr_sel = 1'b0;
    end
  endtask
  // Event, then a read sampled on the very next edge
  task pulse_rd(input [3:0] e, input [1:0] a, input [7:0] want);
    begin
      @(posedge clk);
      #1 ev = e;
      @(posedge clk);
      #1 ev = 4'h0;
      sfr_sel = 1'b1;
      sfr_wr = 1'b0;
      sfr_addr = a;
      exp_q.push_back(want);
      @(posedge clk);
      #1;
      sfr_sel = 1'b0;
    end
  endtask
  task pulse(input [3:0] e);
    begin
      @(posedge clk);
      #1 ev = e;
      @(posedge clk);
      #1 ev = 4'h0;
    end
  endtask
  always @(posedge clk) begin
    if (rd_seen) check(sfr_rdata, exp_q.pop_front());
    rd_seen <= sfr_sel & ~sfr_wr;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    acc(1'b0, 2'h0, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      acc(1'b1, i[1:0], seed[7:0]);
      acc(1'b0, i[1:0], seed[7:0] & MASKS[i*8 +: 8]);
      acc(1'b1, i[1:0], 8'h00);
    end
    acc(1'b1, 2'h1, 8'h00);
    acc(1'b1, 2'h0, 8'h04);
    acc(1'b1, 2'h2, 8'h02);
    acc(1'b1, 2'h1, 8'h01);
    pulse(4'h5);
    check(irq_req, 1'b0);
    check(irq_vector, `MIFEB_VEC_NONE);
    acc(1'b0, 2'h0, 8'h24);
    acc(1'b0, 2'h1, 8'h11);
    acc(1'b0, 2'h2, 8'h22);
    acc(1'b1, 2'h0, 8'h25);
    check(irq_req, 1'b1);
    check(irq_vector, `MIFEB_VEC_TICK);
    pulse(4'ha);
    check(irq_req, 1'b0);
    acc(1'b0, 2'h0, 8'h04);
    acc(1'b0, 2'h2, 8'h32);
    acc(1'b1, 2'h0, 8'h05);
    check(irq_vector, `MIFEB_VEC_GROUPED);
    pulse(4'h8);
    acc(1'b0, 2'h1, 8'h01);
    acc(1'b0, 2'h2, 8'h32);
    acc(1'b1, 2'h2, 8'h03);
    pulse_rd(4'h2, 2'h2, 8'h13);
    pulse_rd(4'h4, 2'h2, 8'h33);
    pulse_rd(4'h1, 2'h0, 8'h24);
    acc(1'b1, 2'h1, 8'h10);
    acc(1'b1, 2'h0, 8'h21);
    check(irq_req, 1'b0);
    check(irq_vector, `MIFEB_VEC_NONE);
    acc(1'b0, 2'h0, 8'h21);
    acc(1'b0, 2'h1, 8'h10);
    repeat (2) @(posedge clk);
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count = bad_count + 1;
    finish_test;
  end
endmodule // mifeb_bank_tb
bind mifeb_bank mifeb_bank_properties i_props (.clk, .rst_n, .sfr_sel, .sfr_wr, .sfr_addr, .sfr_wdata,
  .sfr_rdata, .tick_overflow, .cmp_p_match, .cmp_a_match, .irq_req, .irq_vector, .irq_ack);
